/* File: shared/svpd_pkg.sv */
package svpd_pkg;

  // ****************************************************************
  // sizes of the control core
  // ****************************************************************
  localparam int unsigned NUM_MON  = 6;   // supply comparators
  localparam int unsigned NUM_PIN  = 5;   // bidirectional open-drain pins
  localparam int unsigned NUM_TMR  = 4;   // programmable timers
  localparam int unsigned NUM_TERM = 10;  // product terms of the logic array
  localparam int unsigned LIN_W    = 17;  // logic array input vector width

  // ****************************************************************
  // timing, clk is 250 MHz
  // ****************************************************************
  localparam int unsigned CLK_PERIOD_PS   = 4000;
  localparam int unsigned TICK_TIME_US    = 32;
  localparam int unsigned TICK_CYCLES     = (TICK_TIME_US * 1000000) / CLK_PERIOD_PS;
  localparam int unsigned FILT_OFF_US     = 12;
  localparam int unsigned FILT_OFF_CYCLES = (FILT_OFF_US * 1000000) / CLK_PERIOD_PS;
  localparam int unsigned FILT_ON_US      = 48;
  localparam int unsigned FILT_ON_CYCLES  = (FILT_ON_US * 1000000) / CLK_PERIOD_PS;
  localparam int unsigned CNT_W           = 16;  // prescaler and filter counters
  localparam int unsigned TMR_CNT_W       = 17;  // timer count of 32 us ticks
  localparam int unsigned TMR_SET_W       = 7;   // 128 settings per timer
  localparam int unsigned TMR_EXP_MAX     = 6;   // exponent clamp, 65536 ticks max

  // ****************************************************************
  // register byte offsets
  // ****************************************************************
  localparam logic [7:0] REG_CTRL      = 8'h00;
  localparam logic [7:0] REG_STATUS    = 8'h04;
  localparam logic [7:0] REG_TMR       = 8'h08;
  localparam logic [7:0] REG_TERM_BASE = 8'h10;
  localparam logic [5:0] TERM_IDX_BASE = 6'h04;  // word index of first term

  // ****************************************************************
  // field positions, writable masks, reset values
  // ****************************************************************
  localparam int unsigned CTRL_PD_EN_BIT  = 0;
  localparam int unsigned CTRL_PD_SRC_BIT = 1;   // 0 wake pin, 1 logic request
  localparam int unsigned CTRL_DIR_LSB    = 2;   // 1 = pin is an output
  localparam int unsigned CTRL_FILT_LSB   = 8;   // 1 = glitch filter on
  localparam int unsigned STAT_PD_BIT     = 24;
  localparam int unsigned STAT_SLEEP_BIT  = 25;
  localparam int unsigned TMR_FIELD_STRIDE = 8;
  localparam int unsigned TERM_INV_BIT    = 31;
  localparam int unsigned TERM_OUT0       = 0;   // terms 0..4 drive the pins
  localparam int unsigned TERM_TMR0       = 5;   // terms 5..8 run the timers
  localparam int unsigned TERM_SLEEP      = 9;   // term 9 is the sleep request
  localparam logic [31:0] CTRL_WMASK      = 32'h0000_3fff;
  localparam logic [31:0] TMR_WMASK       = 32'h7f7f_7f7f;
  localparam logic [31:0] TERM_WMASK      = 32'h8001_ffff;
  localparam logic [31:0] CTRL_RST        = 32'h0000_0000;
  localparam logic [31:0] TMR_RST         = 32'h0000_0000;
  localparam logic [31:0] TERM_RST        = 32'h8000_0000;  // empty mask, inverted: false

  typedef enum logic [0:0] {
    SVPD_PD_RUN   = 1'b0,
    SVPD_PD_SLEEP = 1'b1
  } svpd_pd_state_t;

endpackage

/* File: src/svpd_timer.sv */
`timescale 1ns/1ps

module svpd_timer (
  input  wire logic                           clk,     // core clock
  input  wire logic                           srst,    // sync reset
  input  wire logic                           tick,    // one pulse per 32 us
  input  wire logic                           start,   // level, runs while high
  input  wire logic [svpd_pkg::TMR_SET_W-1:0] setting, // mantissa [3:0], exponent [6:4]
  output logic                                done     // level, timeout reached
);

  typedef struct packed {
    logic [svpd_pkg::TMR_CNT_W-1:0] cnt;
    logic                           done;
  } svpd_tmr_state_t;

  svpd_tmr_state_t s_reg;
  svpd_tmr_state_t s_next;
  logic [svpd_pkg::TMR_CNT_W-1:0] limit;
  logic [2:0]                     expo;

  // limit in ticks = (mantissa + 1) << (2 * exponent), exponent 7 clamps to 6
  always_comb
  begin
    expo  = (setting[6:4] > 3'(svpd_pkg::TMR_EXP_MAX)) ? 3'(svpd_pkg::TMR_EXP_MAX) : setting[6:4];
    limit = (svpd_pkg::TMR_CNT_W)'({1'b0, setting[3:0]} + 5'h01) << {expo, 1'b0};
  end

  // dropping start clears the timer at once, so a restart always counts from zero
  always_comb
  begin
    s_next = s_reg;
    if (!start)
    begin
      s_next.cnt  = '0;
      s_next.done = 1'b0;
    end
    else if (tick && !s_reg.done)
    begin
      s_next.cnt = s_reg.cnt + 1'b1;
      if (s_reg.cnt + 1'b1 >= limit)
      begin
        s_next.done = 1'b1;
      end
    end
  end

  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      s_reg <= '0;
    end
    else
    begin
      s_reg <= s_next;
    end
  end

  assign done = s_reg.done;

  // ****************************************************************
  // assertions
  // ****************************************************************
  property p_tmr_clear;
    @(posedge clk) disable iff (srst) !start |=> !done && s_reg.cnt == '0;
  endproperty
  a_tmr_clear: assert property (p_tmr_clear) else $error("timer not cleared without start");

  property p_tmr_limit;
    @(posedge clk) disable iff (srst) $rose(done) |-> s_reg.cnt == $past(limit);
  endproperty
  a_tmr_limit: assert property (p_tmr_limit) else $error("timer fired at wrong tick count");

endmodule

/* File: src/svpd_core.sv */
// Design decisions made here: the register addresses and register access over Avalon-MM.
`timescale 1ns/1ps

// Notes on behaviour
// - enabled power-down follows wake level: low enters
// - power-down source: wake pin or logic request
// - with logic source, wake only exits, high
// - dedicated inputs and input pins are clock-sampled
// - each pin is open-drain output or input
// - logic array alone drives pins, low or float
// - four independent timers, 32us to 2s
// - comparators and inputs all feed logic array
// - each timer has 128 timeout settings
// - glitch filter gives 48us, else 12us

module svpd_core #(
  parameter int unsigned TICK_CYCLES_P    = svpd_pkg::TICK_CYCLES,    // 32 us timer tick
  parameter int unsigned FILT_ON_CYCLES_P = svpd_pkg::FILT_ON_CYCLES  // filtered delay
) (
  input  wire logic                         clk,                     // core clock, 250 MHz
  input  wire logic                         srst,                    // sync reset, active high
  input  wire logic [7:0]                   avs_address,             // byte address
  input  wire logic                         avs_read,                // read request
  input  wire logic                         avs_write,               // write request
  input  wire logic [31:0]                  avs_writedata,           // write data
  input  wire logic [3:0]                   avs_byteenable,          // write byte lanes
  output logic      [31:0]                  avs_readdata,            // read data, registered
  output logic                              avs_waitrequest,         // stall
  input  wire logic                         wake_sleep_input,        // wake / sleep pin
  input  wire logic                         aux_logic_input,         // second logic input pin
  input  wire logic [svpd_pkg::NUM_MON-1:0] supply_monitor_input,    // comparator results
  input  wire logic [svpd_pkg::NUM_PIN-1:0] bidir_open_drain_pins_i, // pad levels
  output logic      [svpd_pkg::NUM_PIN-1:0] bidir_open_drain_pins_o, // always low
  output logic      [svpd_pkg::NUM_PIN-1:0] bidir_open_drain_pins_oe,// pull low when high
  output logic                              power_down               // device in power-down
);

  // ****************************************************************
  // state
  // ****************************************************************
  typedef struct packed {
    logic [6:0]                                        sync1;   // wake, aux, pins
    logic [6:0]                                        sync2;
    logic [svpd_pkg::NUM_MON-1:0]                      cmp1;
    logic [svpd_pkg::NUM_MON-1:0]                      cmp2;
    logic [svpd_pkg::NUM_MON-1:0]                      cmp_f;   // filtered comparators
    logic [svpd_pkg::NUM_MON-1:0][svpd_pkg::CNT_W-1:0] flt_cnt;
    logic [svpd_pkg::CNT_W-1:0]                        pre_cnt;
    logic                                              tick;
    svpd_pkg::svpd_pd_state_t                          pd;
    logic [31:0]                                       ctrl;
    logic [31:0]                                       tmr;
    logic [svpd_pkg::NUM_TERM-1:0][31:0]               term;
    logic [svpd_pkg::NUM_PIN-1:0]                      pin_drv;
    logic                                              ack;
    logic [31:0]                                       rdata;
  } svpd_state_t;

  svpd_state_t s_reg;
  svpd_state_t s_next;

  logic [svpd_pkg::NUM_TMR-1:0]  tmr_done;
  logic [svpd_pkg::LIN_W-1:0]    lin;
  logic [svpd_pkg::NUM_TERM-1:0] term_hit;
  logic                          wake_s;
  logic                          req;
  logic [5:0]                    widx;
  logic [3:0]                    tidx;
  logic                          term_sel;

  // ****************************************************************
  // helpers
  // ****************************************************************
  // a product term is true when every masked input is high, then optionally inverted
  function automatic logic term_eval(input logic [31:0] t, input logic [svpd_pkg::LIN_W-1:0] v);
    term_eval = ((t[svpd_pkg::LIN_W-1:0] & v) == t[svpd_pkg::LIN_W-1:0]) ^ t[svpd_pkg::TERM_INV_BIT];
  endfunction

  // byte-lane merge limited to the writable bits of a register
  function automatic logic [31:0] be_merge(input logic [31:0] old, input logic [31:0] wd,
                                           input logic [3:0] be, input logic [31:0] wmask);
    logic [31:0] lanes;
    lanes    = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}} & wmask;
    be_merge = (old & ~lanes) | (wd & lanes);
  endfunction

  // ****************************************************************
  // logic array inputs and product terms
  // ****************************************************************
  // comparators, both inputs, all pins and the timer outputs reach every term
  assign wake_s = s_reg.sync2[0];
  assign lin    = {tmr_done, s_reg.sync2[6:2], s_reg.sync2[1], wake_s, s_reg.cmp_f};

  always_comb
  begin
    for (int i = 0; i < svpd_pkg::NUM_TERM; i++)
    begin
      term_hit[i] = term_eval(s_reg.term[i], lin);
    end
  end

  // ****************************************************************
  // timers
  // ****************************************************************
  for (genvar g = 0; g < svpd_pkg::NUM_TMR; g++)
  begin : g_tmr
    svpd_timer u_tmr (
      .clk     (clk),
      .srst    (srst),
      .tick    (s_reg.tick),
      .start   (term_hit[svpd_pkg::TERM_TMR0 + g]),
      .setting (s_reg.tmr[g*svpd_pkg::TMR_FIELD_STRIDE +: svpd_pkg::TMR_SET_W]),
      .done    (tmr_done[g])
    );
  end

  // ****************************************************************
  // register bus decode
  // ****************************************************************
  // one wait cycle per access: the read word is built while the master waits
  assign req             = avs_read | avs_write;
  assign avs_waitrequest = req & ~s_reg.ack;
  assign widx            = avs_address[7:2];
  assign tidx            = 4'(widx - svpd_pkg::TERM_IDX_BASE);
  assign term_sel        = (avs_address >= svpd_pkg::REG_TERM_BASE) && (tidx < 4'(svpd_pkg::NUM_TERM));

  // ****************************************************************
  // next state
  // ****************************************************************
  always_comb
  begin
    s_next = s_reg;

    // pins are sampled even when driven, so software can see a wired level
    s_next.sync1 = {bidir_open_drain_pins_i, aux_logic_input, wake_sleep_input};
    s_next.sync2 = s_reg.sync1;
    s_next.cmp1  = supply_monitor_input;
    s_next.cmp2  = s_reg.cmp1;

    // free-running prescaler, so the first tick may come early by up to one period
    s_next.tick = 1'b0;
    if (s_reg.pre_cnt >= svpd_pkg::CNT_W'(TICK_CYCLES_P - 1))
    begin
      s_next.pre_cnt = '0;
      s_next.tick    = 1'b1;
    end
    else
    begin
      s_next.pre_cnt = s_reg.pre_cnt + 1'b1;
    end

    // a comparator change must hold for the whole delay before it is passed on
    for (int m = 0; m < svpd_pkg::NUM_MON; m++)
    begin
      if (s_reg.cmp2[m] == s_reg.cmp_f[m])
      begin
        s_next.flt_cnt[m] = '0;
      end
      else if (s_reg.flt_cnt[m] >= (s_reg.ctrl[svpd_pkg::CTRL_FILT_LSB + m] ?
                                    svpd_pkg::CNT_W'(FILT_ON_CYCLES_P - 1) :
                                    svpd_pkg::CNT_W'(svpd_pkg::FILT_OFF_CYCLES - 1)))
      begin
        s_next.cmp_f[m]   = s_reg.cmp2[m];
        s_next.flt_cnt[m] = '0;
      end
      else
      begin
        s_next.flt_cnt[m] = s_reg.flt_cnt[m] + 1'b1;
      end
    end

    // power-down control
    unique case (s_reg.pd)
      svpd_pkg::SVPD_PD_RUN:
      begin
        if (s_reg.ctrl[svpd_pkg::CTRL_PD_EN_BIT])
        begin
          if (s_reg.ctrl[svpd_pkg::CTRL_PD_SRC_BIT])
          begin
            if (term_hit[svpd_pkg::TERM_SLEEP])
            begin
              s_next.pd = svpd_pkg::SVPD_PD_SLEEP;
            end
          end
          else if (!wake_s)
          begin
            s_next.pd = svpd_pkg::SVPD_PD_SLEEP;
          end
        end
      end
      svpd_pkg::SVPD_PD_SLEEP:
      begin
        // the wake pin or a cleared enable bit ends power-down, whichever source started it
        if (wake_s || !s_reg.ctrl[svpd_pkg::CTRL_PD_EN_BIT])
        begin
          s_next.pd = svpd_pkg::SVPD_PD_RUN;
        end
      end
    endcase

    // bus access: write lands and read data stands on the edge with waitrequest low
    s_next.ack = req & ~s_reg.ack;
    if (avs_read && !s_reg.ack)
    begin
      s_next.rdata = 32'h0000_0000;
      if (avs_address == svpd_pkg::REG_CTRL)
      begin
        s_next.rdata = s_reg.ctrl;
      end
      else if (avs_address == svpd_pkg::REG_STATUS)
      begin
        s_next.rdata[svpd_pkg::LIN_W-1:0]       = lin;
        s_next.rdata[svpd_pkg::STAT_PD_BIT]     = s_reg.pd == svpd_pkg::SVPD_PD_SLEEP;
        s_next.rdata[svpd_pkg::STAT_SLEEP_BIT]  = term_hit[svpd_pkg::TERM_SLEEP];
      end
      else if (avs_address == svpd_pkg::REG_TMR)
      begin
        s_next.rdata = s_reg.tmr;
      end
      else if (term_sel && avs_address[1:0] == 2'h0)
      begin
        s_next.rdata = s_reg.term[tidx];
      end
    end
    if (avs_write && s_reg.ack)
    begin
      if (avs_address == svpd_pkg::REG_CTRL)
      begin
        s_next.ctrl = be_merge(s_reg.ctrl, avs_writedata, avs_byteenable, svpd_pkg::CTRL_WMASK);
      end
      else if (avs_address == svpd_pkg::REG_TMR)
      begin
        s_next.tmr = be_merge(s_reg.tmr, avs_writedata, avs_byteenable, svpd_pkg::TMR_WMASK);
      end
      else if (term_sel && avs_address[1:0] == 2'h0)
      begin
        s_next.term[tidx] = be_merge(s_reg.term[tidx], avs_writedata, avs_byteenable,
                                     svpd_pkg::TERM_WMASK);
      end
    end

    // open drain: uses the new direction, so a pin turned to input never drives a cycle late
    s_next.pin_drv = '0;
    if (s_next.pd == svpd_pkg::SVPD_PD_RUN)
    begin
      for (int p = 0; p < svpd_pkg::NUM_PIN; p++)
      begin
        s_next.pin_drv[p] = s_next.ctrl[svpd_pkg::CTRL_DIR_LSB + p] &
                            term_hit[svpd_pkg::TERM_OUT0 + p];
      end
    end
  end

  // ****************************************************************
  // registers
  // ****************************************************************
  // reset leaves every term false, so timers stay clear and pins float
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      s_reg      <= '0;
      s_reg.ctrl <= svpd_pkg::CTRL_RST;
      s_reg.tmr  <= svpd_pkg::TMR_RST;
      s_reg.term <= {svpd_pkg::NUM_TERM{svpd_pkg::TERM_RST}};
      s_reg.pd   <= svpd_pkg::SVPD_PD_RUN;
    end
    else
    begin
      s_reg <= s_next;
    end
  end

  assign avs_readdata             = s_reg.rdata;
  assign bidir_open_drain_pins_o  = '0;
  assign bidir_open_drain_pins_oe = s_reg.pin_drv;
  assign power_down               = s_reg.pd == svpd_pkg::SVPD_PD_SLEEP;

  // ****************************************************************
  // assertions
  // ****************************************************************
  property p_pd_enter_pin;
    @(posedge clk) disable iff (srst)
      s_reg.pd == svpd_pkg::SVPD_PD_RUN && s_reg.ctrl[0] && !s_reg.ctrl[1] && !wake_s |=> power_down;
  endproperty
  a_pd_enter_pin: assert property (p_pd_enter_pin) else $error("low wake did not enter power-down");

  property p_pd_exit;
    @(posedge clk) disable iff (srst) power_down && wake_s |=> !power_down;
  endproperty
  a_pd_exit: assert property (p_pd_exit) else $error("high wake did not leave power-down");

  property p_pd_logic_src;
    @(posedge clk) disable iff (srst)
      !power_down && s_reg.ctrl[0] && s_reg.ctrl[1] && term_hit[9] |=> power_down;
  endproperty
  a_pd_logic_src: assert property (p_pd_logic_src) else $error("sleep request ignored");

  property p_pd_no_pin_entry;
    @(posedge clk) disable iff (srst)
      !power_down && s_reg.ctrl[1] && !term_hit[9] |=> !power_down;
  endproperty
  a_pd_no_pin_entry: assert property (p_pd_no_pin_entry) else $error("wake pin entered power-down");

  property p_sync_two;
    @(posedge clk) disable iff (srst)
      !$past(srst, 1) && !$past(srst, 2) |-> s_reg.sync2 ==
        $past({bidir_open_drain_pins_i, aux_logic_input, wake_sleep_input}, 2);
  endproperty
  a_sync_two: assert property (p_sync_two) else $error("input not synchronised in two stages");

  property p_od_dir;
    @(posedge clk) disable iff (srst)
      (bidir_open_drain_pins_oe & ~s_reg.ctrl[6:2]) == '0 && bidir_open_drain_pins_o == '0;
  endproperty
  a_od_dir: assert property (p_od_dir) else $error("input pin or high level driven");

  property p_pin_follows_term;
    @(posedge clk) disable iff (srst)
      !power_down && s_reg.ctrl[2] && term_hit[0] ##1 !power_down && s_reg.ctrl[2] |->
        bidir_open_drain_pins_oe[0];
  endproperty
  a_pin_follows_term: assert property (p_pin_follows_term) else $error("output term not driven");

  property p_reset_release;
    @(posedge clk) $fell(srst) |-> bidir_open_drain_pins_oe == '0 && tmr_done == '0 && !power_down;
  endproperty
  a_reset_release: assert property (p_reset_release) else $error("pins or timers busy after reset");

  property p_timer_cause;
    @(posedge clk) disable iff (srst) tmr_done[0] |-> $past(term_hit[5]);
  endproperty
  a_timer_cause: assert property (p_timer_cause) else $error("timer done without start");

  property p_filter_settle;
    @(posedge clk) disable iff (srst)
      s_reg.cmp_f[0] != $past(s_reg.cmp_f[0]) |-> $past(s_reg.cmp2[0]) == s_reg.cmp_f[0] &&
        $past(s_reg.flt_cnt[0]) != '0;
  endproperty
  a_filter_settle: assert property (p_filter_settle) else $error("comparator passed unfiltered");

  c_pd_pin:   cover property (@(posedge clk) disable iff (srst) !s_reg.ctrl[1] && $rose(power_down));
  c_pd_logic: cover property (@(posedge clk) disable iff (srst) s_reg.ctrl[1] && $rose(power_down));
  c_tmr_done: cover property (@(posedge clk) disable iff (srst) $rose(tmr_done[0]));
  c_pin_low:  cover property (@(posedge clk) disable iff (srst) $rose(bidir_open_drain_pins_oe[0]));

endmodule

/* File: testbench/svpd_far_side.sv */
`timescale 1ns/1ps

// ****************************************
// far side: board pull-ups and other drivers
// ****************************************
module svpd_far_side (
  input  wire logic [svpd_pkg::NUM_PIN-1:0] pin_oe,  // device pulls pin low
  input  wire logic [svpd_pkg::NUM_PIN-1:0] ext_low, // outside party pulls low
  output logic      [svpd_pkg::NUM_PIN-1:0] pad      // resolved pad level
);
  // wired-and: the pull-up only wins when nobody sinks the line
  assign pad = ~(pin_oe | ext_low);
endmodule

/* File: testbench/tb_top.sv */
`timescale 1ns/1ps

module tb_top;
  logic        clk, srst, rd, wr, wake, aux, waitreq, pd;
  logic [7:0]  addr;
  logic [31:0] wdata, rdata, q;
  logic [5:0]  mon;
  logic [4:0]  oe, ext_low, pad;
  int          n_fail, checks_done;

  svpd_core #(.TICK_CYCLES_P(4), .FILT_ON_CYCLES_P(8)) i_svpd_core (
    .clk(clk), .srst(srst), .avs_address(addr), .avs_read(rd), .avs_write(wr),
    .avs_writedata(wdata), .avs_byteenable(4'hf), .avs_readdata(rdata),
    .avs_waitrequest(waitreq), .wake_sleep_input(wake), .aux_logic_input(aux),
    .supply_monitor_input(mon), .bidir_open_drain_pins_i(pad), .bidir_open_drain_pins_o(),
    .bidir_open_drain_pins_oe(oe), .power_down(pd));
  svpd_far_side i_svpd_far_side (.pin_oe(oe), .ext_low(ext_low), .pad(pad));

  // ****************************************
  // clock and shared tasks
  // ****************************************
  initial
  begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      $display("BAD %s exp %h seen %h", nm, exp, seen);
      n_fail++;
    end
  endtask

  // one access; holds the request until waitrequest is seen low
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= w;
    rd <= !w;
    // waitrequest and read data are taken at the same rising edge
    for (n = 0; n < 50; n++)
    begin
      @(posedge clk);
      if (waitreq === 1'b0)
        break;
    end
    if (n == 50)
      chk("bus", 0, 1);
    q = rdata;
    rd <= 1'b0;
    wr <= 1'b0;
  endtask

  // pin levels settle through two sync flops plus one register
  task automatic wait_pd(input logic exp);
    for (int n = 0; n < 40 && pd !== exp; n++)
      @(negedge clk);
    chk("power_down", {31'h0, pd}, {31'h0, exp});
  endtask

  // ****************************************
  // scenarios
  // ****************************************
  task automatic t_reset;
    bus(0, 8'h00, 0); chk("ctrl", q, 32'h0);
    bus(0, 8'h08, 0); chk("tmr", q, 32'h0);
    bus(0, 8'h10, 0); chk("term0", q, 32'h8000_0000);
    bus(0, 8'h80, 0); chk("unmapped", q, 32'h0);
    chk("oe", {27'h0, oe}, 0);
  endtask

  task automatic t_pins;
    bus(1, 8'h10, 0);
    bus(1, 8'h14, 0);
    bus(1, 8'h00, 32'h4);
    ext_low <= 5'h02;
    repeat (8) @(posedge clk);
    chk("oe", {27'h0, oe}, 32'h1);
    bus(0, 8'h04, 0); chk("pads", {27'h0, q[12:8]}, 32'h1c);
  endtask

  task automatic t_pd_pin;
    bus(1, 8'h00, 32'h5);
    wake <= 1'b0;
    wait_pd(1);
    @(negedge clk); chk("oe in sleep", {27'h0, oe}, 0);
    @(posedge clk);
    wake <= 1'b1;
    wait_pd(0);
    repeat (3) @(negedge clk); chk("oe awake", {27'h0, oe}, 1);
  endtask

  task automatic t_pd_logic;
    bus(1, 8'h00, 32'h3);
    wake <= 1'b0;
    repeat (12) @(posedge clk);
    chk("pd wake low", {31'h0, pd}, 0);
    bus(1, 8'h34, 0);
    wait_pd(1);
    bus(1, 8'h34, 32'h8000_0000);
    wake <= 1'b1;
    wait_pd(0);
  endtask

  // setting 3: four 32 us ticks, each 4 cycles here
  task automatic t_timer;
    bus(1, 8'h08, 32'h3);
    bus(1, 8'h24, 0);
    bus(0, 8'h04, 0); chk("early", {31'h0, q[13]}, 0);
    repeat (30) @(posedge clk);
    bus(0, 8'h04, 0); chk("done", {31'h0, q[13]}, 1);
    bus(1, 8'h24, 32'h8000_0000);
    bus(0, 8'h04, 0); chk("clear", {31'h0, q[13]}, 0);
  endtask

  // filter on for monitor 0: eight cycles here, others still in their long unfiltered delay
  task automatic t_filter;
    bus(1, 8'h00, 32'h100);
    repeat (20) @(posedge clk);
    bus(0, 8'h04, 0); chk("cmp high", {26'h0, q[5:0]}, 32'h1);
    mon[0] <= 1'b0;
    bus(0, 8'h04, 0); chk("cmp held", {31'h0, q[0]}, 1);
    repeat (20) @(posedge clk);
    bus(0, 8'h04, 0); chk("cmp low", {31'h0, q[0]}, 0);
  endtask

  task automatic give_verdict;
    $display("checks %0d mismatches %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  // ****************************************
  // main sequence and watchdog
  // ****************************************
  initial
  begin
    {rd, wr, addr, wdata, ext_low} = '0;
    {wake, aux, mon} = '1;
    srst = 1'b1;
    repeat (3) @(posedge clk);
    srst <= 1'b0;
    t_reset;
    t_pins;
    t_pd_pin;
    t_pd_logic;
    t_timer;
    t_filter;
    give_verdict;
  end

  // generous span, 10000 cycles, for about 200 cycles of tests
  initial
  begin
    #40000;
    n_fail++;
    give_verdict;
  end
endmodule
